// file: verilog/tic_top.sv
`default_nettype none
module tic_top #(
  parameter int PRE_TICKS = tic_pkg::TICKS_PER_SUB
) (
  input  wire logic        CORE_CLK_IN,    // core clock, 25 MHz
  input  wire logic        RESETN_IN,      // async reset, active low
  input  wire logic        XTAL_TICK_IN,   // one-cycle pulse per crystal period
  input  wire logic        POWER_DOWN_IN,  // chip is in power-down
  input  wire logic        INT_EN_IN,      // interval interrupt enabled by core
  input  wire logic [7:0]  SFR_ADDR_IN,    // special function address
  input  wire logic        SFR_WR_IN,      // write request pulse
  input  wire logic        SFR_RD_IN,      // read request pulse
  input  wire logic [7:0]  SFR_WDATA_IN,   // write data
  output logic      [7:0]  SFR_RDATA_OUT,  // read data, valid with ack
  output logic             SFR_ACK_OUT,    // access done pulse
  output logic             SFR_BUSY_OUT,   // access waiting for crystal tick
  output logic             IRQ_OUT,        // interval interrupt request
  output logic             WAKE_OUT,       // wake from power-down
  output logic      [15:0] VECTOR_OUT      // interrupt vector address
);
  // prescaler is 8 bits wide; one tick per step would break the carry chain
  if (PRE_TICKS < 2 || PRE_TICKS > 256)
  begin : g_bad_pre
    $error("PRE_TICKS out of range");
  end

  logic [7:0]       ctrl_q, ctrl_d, cmp_q, cmp_d, cnt_q, cnt_d, hour_q, hour_d, rdata_q, rdata_d;
  logic [6:0]       sub_q, sub_d, sub_w_q, sub_w_d;
  logic [5:0]       sec_q, sec_d, min_q, min_d, sec_w_q, sec_w_d, min_w_q, min_w_d;
  logic [7:0]       hour_w_q, hour_w_d, pre_q, pre_d;
  logic [7:0]       acc_addr_q, acc_addr_d, acc_data_q, acc_data_d;
  logic             acc_we_q, acc_we_d, ack_q, ack_d;
  tic_pkg::tic_acc_t st_q, st_d;
  logic             time_en, ien, run, ovf_pre, ovf_sub, ovf_sec, ovf_min, step, hit, mapped, wr_now;
  logic [7:0]       cnt_inc;

  assign time_en = ctrl_q[tic_pkg::BIT_TIME_EN];
  assign ien     = ctrl_q[tic_pkg::BIT_IEN];
  // counting never looks at POWER_DOWN_IN
  assign run     = XTAL_TICK_IN && time_en;
  assign ovf_pre = run && (pre_q == 8'(PRE_TICKS - 1));
  assign ovf_sub = ovf_pre && (sub_q == tic_pkg::SUB_MAX);
  assign ovf_sec = ovf_sub && (sec_q == tic_pkg::SEC_MAX);
  assign ovf_min = ovf_sec && (min_q == tic_pkg::MIN_MAX);
  assign cnt_inc = cnt_q + 8'h01;
  assign hit     = ien && step && (cnt_inc == cmp_q);
  assign mapped  = (SFR_ADDR_IN >= tic_pkg::ADDR_CTRL) && (SFR_ADDR_IN <= tic_pkg::ADDR_CMP);
  assign wr_now  = (st_q == tic_pkg::TIC_PEND) && XTAL_TICK_IN && acc_we_q;

  always_comb
  begin
    case (ctrl_q[tic_pkg::BIT_TB_HI:tic_pkg::BIT_TB_LO])
      tic_pkg::TB_SUBSEC: step = ovf_pre;
      tic_pkg::TB_SEC:    step = ovf_sub;
      tic_pkg::TB_MIN:    step = ovf_sec;
      tic_pkg::TB_HOUR:   step = ovf_min;
      default:            step = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_d     = ctrl_q;
    cmp_d      = cmp_q;
    cnt_d      = cnt_q;
    pre_d      = pre_q;
    sub_d      = sub_q;
    sec_d      = sec_q;
    min_d      = min_q;
    hour_d     = hour_q;
    sub_w_d    = sub_w_q;
    sec_w_d    = sec_w_q;
    min_w_d    = min_w_q;
    hour_w_d   = hour_w_q;
    acc_addr_d = acc_addr_q;
    acc_data_d = acc_data_q;
    acc_we_d   = acc_we_q;
    rdata_d    = rdata_q;
    ack_d      = 1'b0;
    st_d       = st_q;
    // time chain
    if (run)
      pre_d = ovf_pre ? 8'h00 : pre_q + 8'h01;
    if (ovf_pre)
      sub_d = ovf_sub ? 7'h00 : sub_q + 7'h01;
    if (ovf_sub)
      sec_d = ovf_sec ? 6'h00 : sec_q + 6'h01;
    if (ovf_sec)
      min_d = ovf_min ? 6'h00 : min_q + 6'h01;
    if (ovf_min)
      hour_d = (ctrl_q[tic_pkg::BIT_HWRAP] && hour_q == tic_pkg::HOUR_MAX_24) ? 8'h00 : hour_q + 8'h01;
    // interval counter: 8 bits against 1/128 s .. hours gives the full span
    if (!ien)
      cnt_d = 8'h00;
    else if (hit)
    begin
      cnt_d                     = 8'h00;
      ctrl_d[tic_pkg::BIT_FLAG] = 1'b1;
      if (ctrl_q[tic_pkg::BIT_SSHOT])
        ctrl_d[tic_pkg::BIT_IEN] = 1'b0;
    end
    else if (step)
      cnt_d = cnt_inc;
    // accesses wait for a crystal tick so they land in step with the counters
    case (st_q)
      tic_pkg::TIC_IDLE:
      begin
        if ((SFR_WR_IN || SFR_RD_IN) && mapped)
        begin
          acc_addr_d = SFR_ADDR_IN;
          acc_data_d = SFR_WDATA_IN;
          acc_we_d   = SFR_WR_IN;
          st_d       = tic_pkg::TIC_PEND;
        end
      end
      tic_pkg::TIC_PEND:
      begin
        if (XTAL_TICK_IN)
        begin
          ack_d = 1'b1;
          st_d  = tic_pkg::TIC_IDLE;
          case (acc_addr_q)
            tic_pkg::ADDR_CTRL: rdata_d = {1'b0, ctrl_q[6:0]};
            tic_pkg::ADDR_SUB:  rdata_d = {1'b0, sub_q};
            tic_pkg::ADDR_SEC:  rdata_d = {2'b00, sec_q};
            tic_pkg::ADDR_MIN:  rdata_d = {2'b00, min_q};
            tic_pkg::ADDR_HOUR: rdata_d = hour_q;
            tic_pkg::ADDR_CMP:  rdata_d = cmp_q;
            default:            rdata_d = 8'h00;
          endcase
          if (acc_we_q)
          begin
            rdata_d = 8'h00;
            case (acc_addr_q)
              tic_pkg::ADDR_CTRL:
              begin
                ctrl_d = {1'b0, acc_data_q[6:0]};
                // software can only clear the flag; a same-tick match still sets it
                ctrl_d[tic_pkg::BIT_FLAG] = hit || (ctrl_q[tic_pkg::BIT_FLAG] && acc_data_q[tic_pkg::BIT_FLAG]);
                if (time_en && !acc_data_q[tic_pkg::BIT_TIME_EN])
                begin
                  pre_d  = 8'h00;
                  sub_d  = sub_w_q;
                  sec_d  = sec_w_q;
                  min_d  = min_w_q;
                  hour_d = hour_w_q;
                end
              end
              tic_pkg::ADDR_SUB:
              begin
                sub_d   = acc_data_q[6:0];
                sub_w_d = acc_data_q[6:0];
              end
              tic_pkg::ADDR_SEC:
              begin
                sec_d   = acc_data_q[5:0];
                sec_w_d = acc_data_q[5:0];
              end
              tic_pkg::ADDR_MIN:
              begin
                min_d   = acc_data_q[5:0];
                min_w_d = acc_data_q[5:0];
              end
              tic_pkg::ADDR_HOUR:
              begin
                hour_d   = acc_data_q;
                hour_w_d = acc_data_q;
              end
              tic_pkg::ADDR_CMP: cmp_d = acc_data_q;
              default:           cmp_d = cmp_q;
            endcase
          end
        end
      end
      default: st_d = tic_pkg::TIC_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_q     <= tic_pkg::CTRL_RESET;
      cmp_q      <= 8'h00;
      cnt_q      <= 8'h00;
      pre_q      <= 8'h00;
      sub_q      <= 7'h00;
      sec_q      <= 6'h00;
      min_q      <= 6'h00;
      hour_q     <= 8'h00;
      sub_w_q    <= 7'h00;
      sec_w_q    <= 6'h00;
      min_w_q    <= 6'h00;
      hour_w_q   <= 8'h00;
      acc_addr_q <= 8'h00;
      acc_data_q <= 8'h00;
      acc_we_q   <= 1'b0;
      rdata_q    <= 8'h00;
      ack_q      <= 1'b0;
      st_q       <= tic_pkg::TIC_IDLE;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      cmp_q      <= cmp_d;
      cnt_q      <= cnt_d;
      pre_q      <= pre_d;
      sub_q      <= sub_d;
      sec_q      <= sec_d;
      min_q      <= min_d;
      hour_q     <= hour_d;
      sub_w_q    <= sub_w_d;
      sec_w_q    <= sec_w_d;
      min_w_q    <= min_w_d;
      hour_w_q   <= hour_w_d;
      acc_addr_q <= acc_addr_d;
      acc_data_q <= acc_data_d;
      acc_we_q   <= acc_we_d;
      rdata_q    <= rdata_d;
      ack_q      <= ack_d;
      st_q       <= st_d;
    end
  end

  assign SFR_RDATA_OUT = rdata_q;
  assign SFR_ACK_OUT   = ack_q;
  assign SFR_BUSY_OUT  = (st_q == tic_pkg::TIC_PEND);
  assign IRQ_OUT       = ctrl_q[tic_pkg::BIT_FLAG] && INT_EN_IN;
  assign WAKE_OUT      = IRQ_OUT && POWER_DOWN_IN;
  assign VECTOR_OUT    = tic_pkg::WAKE_VECTOR;

  sub_wrap_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ovf_sub && !wr_now |=> sub_q == 7'h00 && sec_q != $past(sec_q))
    else $error("sub-second did not wrap with carry");
  hour_24_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ovf_min && !wr_now && ctrl_q[6] && hour_q == 8'h17 |=> hour_q == 8'h00)
    else $error("hour did not wrap at 23");
  hour_255_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ovf_min && !wr_now && !ctrl_q[6] && hour_q == 8'h17 |=> hour_q == 8'h18)
    else $error("hour wrapped in 0..255 mode");
  match_flag_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ien && step && cnt_q + 8'h01 == cmp_q |=> ctrl_q[2] && cnt_q == 8'h00)
    else $error("match did not set flag");
  single_shot_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    hit && ctrl_q[3] && !wr_now |=> !ctrl_q[1])
    else $error("single shot left counter enabled");
  wake_flag_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    hit && POWER_DOWN_IN && INT_EN_IN ##1 POWER_DOWN_IN && INT_EN_IN |-> WAKE_OUT)
    else $error("match did not wake device");
  stopped_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    !time_en && !wr_now |=> $stable(sub_q) && $stable(hour_q))
    else $error("time moved while stopped");
  restore_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    wr_now && acc_addr_q == 8'hA1 && time_en && !acc_data_q[0] |=> sub_q == sub_w_q && min_q == min_w_q)
    else $error("stop did not restore written time");
  access_tick_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    SFR_BUSY_OUT && !XTAL_TICK_IN |=> !SFR_ACK_OUT && SFR_BUSY_OUT)
    else $error("access finished without crystal tick");
  bit7_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    wr_now && acc_addr_q == 8'hA1 |=> !ctrl_q[7])
    else $error("control bit 7 stored");
  ien_off_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    !ien |=> cnt_q == 8'h00)
    else $error("counter ran while disabled");
endmodule
`default_nettype wire

// file: verilog/tic_pkg.sv
// Contract
// - time base runs from crystal ticks
// - counting continues during power-down
// - timeouts from 1/128 s to 255 h
// - interval counter steps on selected overflow
// - compare match sets flag, requests interrupt
// - enabled match wakes device, vector 0053H
// - register accesses complete on crystal tick
// - software may preload the time registers
// - six software registers incl. control
// - hour wrap bit picks 23 or 255
// - control bits 5:4 select timebase
// - control bit 7 ignores writes
// - control at A1H, resets to 00H
// - sub-second counts 0..127 then carries
// - enable starts; clearing restores written time
// - interval enable runs 8-bit counter
// - single shot clears enable, else reload
`default_nettype none
package tic_pkg;
  localparam int          XTAL_HZ        = 32768;
  localparam int          SUBSEC_PER_SEC = 128;
  localparam int          TICKS_PER_SUB  = XTAL_HZ / SUBSEC_PER_SEC;
  localparam logic [7:0]  ADDR_CTRL      = 8'hA1;
  localparam logic [7:0]  ADDR_SUB       = 8'hA2;
  localparam logic [7:0]  ADDR_SEC       = 8'hA3;
  localparam logic [7:0]  ADDR_MIN       = 8'hA4;
  localparam logic [7:0]  ADDR_HOUR      = 8'hA5;
  localparam logic [7:0]  ADDR_CMP       = 8'hA6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          BIT_TIME_EN    = 0;
  localparam int          BIT_IEN        = 1;
  localparam int          BIT_FLAG       = 2;
  localparam int          BIT_SSHOT      = 3;
  localparam int          BIT_TB_LO      = 4;
  localparam int          BIT_TB_HI      = 5;
  localparam int          BIT_HWRAP      = 6;
  localparam logic [6:0]  SUB_MAX        = 7'h7F;
  localparam logic [5:0]  SEC_MAX        = 6'h3B;
  localparam logic [5:0]  MIN_MAX        = 6'h3B;
  localparam logic [7:0]  HOUR_MAX_24    = 8'h17;
  localparam logic [1:0]  TB_SUBSEC      = 2'h0;
  localparam logic [1:0]  TB_SEC         = 2'h1;
  localparam logic [1:0]  TB_MIN         = 2'h2;
  localparam logic [1:0]  TB_HOUR        = 2'h3;
  localparam logic [15:0] WAKE_VECTOR    = 16'h0053;
  typedef enum logic {TIC_IDLE = 1'b0, TIC_PEND = 1'b1} tic_acc_t;
endpackage
`default_nettype wire

// file: tb/tic_top_tb.sv
`default_nettype none
module tic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRE      = 2;
  localparam int TICK_DIV = 8; // crystal compressed to keep the run short
  logic        core_clk    = 1'b0;
  logic        resetn;
  logic        xtal_tick   = 1'b0;
  logic        power_down;
  logic        int_en;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  rdata;
  logic        ack;
  logic        busy;
  logic        irq;
  logic        wake;
  logic [15:0] vector;
  logic        got;
  logic        ok;
  logic [7:0]  q;
  int          tick_cnt    = 0;
  int          fail_count  = 0;
  int          check_count = 0;

  tic_top #(.PRE_TICKS(PRE)) DUT (
    .CORE_CLK_IN(core_clk), .RESETN_IN(resetn), .XTAL_TICK_IN(xtal_tick),
    .POWER_DOWN_IN(power_down), .INT_EN_IN(int_en), .SFR_ADDR_IN(sfr_addr),
    .SFR_WR_IN(sfr_wr), .SFR_RD_IN(sfr_rd), .SFR_WDATA_IN(sfr_wdata),
    .SFR_RDATA_OUT(rdata), .SFR_ACK_OUT(ack), .SFR_BUSY_OUT(busy),
    .IRQ_OUT(irq), .WAKE_OUT(wake), .VECTOR_OUT(vector));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    tick_cnt  <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
    xtal_tick <= (tick_cnt == TICK_DIV - 1);
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // caller sits on a rising edge; answer is taken at the edge that sees ack
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic k);
    int   n;
    logic m;
    m = (a >= tic_pkg::ADDR_CTRL) && (a <= tic_pkg::ADDR_CMP);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= w;
    sfr_rd    <= ~w;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    k = 1'b0;
    r = 8'h00;
    n = 0;
    while (k !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
      if (n == 1)
        chk(16'(busy), 16'(m));
      if (ack === 1'b1)
      begin
        k = 1'b1;
        r = rdata;
        chk(16'(busy), 16'h0000);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d, q, ok);
    chk({7'h00, ok, q}, 16'h0100);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, q, ok);
    chk({7'h00, ok, q}, {8'h01, e});
  endtask

  task automatic wait_irq(input int bound);
    int n;
    got = 1'b0;
    n = 0;
    while (got !== 1'b1 && n < bound)
    begin
      @(posedge core_clk);
      n++;
      got = (irq === 1'b1);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    resetn = 1'b0; power_down = 1'b0; int_en = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0;
    sfr_addr = 8'h00; sfr_wdata = 8'h00;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({4'h0, busy, ack, irq, wake, rdata}, 16'h0000);
    for (int i = 0; i < 6; i++) rd(tic_pkg::ADDR_CTRL + 8'(i), 8'h00);
    chk(vector, tic_pkg::WAKE_VECTOR);
    acc(1'b0, 8'hA7, 8'h00, q, ok);
    chk(16'(ok), 16'h0000);
    wr(tic_pkg::ADDR_CTRL, 8'hFF);
    rd(tic_pkg::ADDR_CTRL, 8'h7B);
    $display("test reset_and_control done");
    for (int w = 0; w < 2; w++)
    begin
      wr(tic_pkg::ADDR_CTRL, 8'h00);
      wr(tic_pkg::ADDR_SUB, 8'h7F);
      wr(tic_pkg::ADDR_SEC, 8'h3B);
      wr(tic_pkg::ADDR_MIN, 8'h3B);
      wr(tic_pkg::ADDR_HOUR, 8'h17);
      wr(tic_pkg::ADDR_CTRL, (w == 1) ? 8'h41 : 8'h01);
      repeat (40) @(posedge core_clk);
      rd(tic_pkg::ADDR_HOUR, (w == 1) ? 8'h00 : 8'h18);
      rd(tic_pkg::ADDR_MIN, 8'h00);
      wr(tic_pkg::ADDR_CTRL, 8'h00);
      rd(tic_pkg::ADDR_SEC, 8'h3B);
      rd(tic_pkg::ADDR_HOUR, 8'h17);
    end
    $display("test hour_wrap done");
    // negative pass preloads one level short, so a too-fast timebase shows up
    for (int tb = 0; tb < 4; tb++)
      for (int ng = 0; ng < 2; ng++)
        if (!(tb == 0 && ng == 1))
        begin
          wr(tic_pkg::ADDR_CTRL, 8'h00);
          wr(tic_pkg::ADDR_SUB, (tb - ng >= 1) ? 8'h7F : 8'h00);
          wr(tic_pkg::ADDR_SEC, (tb - ng >= 2) ? 8'h3B : 8'h00);
          wr(tic_pkg::ADDR_MIN, (tb - ng >= 3) ? 8'h3B : 8'h00);
          wr(tic_pkg::ADDR_CMP, 8'h01);
          wr(tic_pkg::ADDR_CTRL, {2'b00, 2'(tb), 4'hB});
          wait_irq(60);
          chk(16'(got), (ng == 0) ? 16'h0001 : 16'h0000);
          if (ng == 0) rd(tic_pkg::ADDR_CTRL, {2'b00, 2'(tb), 4'hD});
        end
    $display("test timebase done");
    wr(tic_pkg::ADDR_CTRL, 8'h00);
    wr(tic_pkg::ADDR_CMP, 8'h03);
    power_down <= 1'b1;
    wr(tic_pkg::ADDR_CTRL, 8'h03);
    wait_irq(100);
    chk(16'(got), 16'h0001);
    chk(16'(wake), 16'h0001);
    wr(tic_pkg::ADDR_CTRL, 8'h03);
    chk(16'(irq), 16'h0000);
    wait_irq(100);
    chk(16'(got), 16'h0001);
    int_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({7'h00, irq, 7'h00, wake}, 16'h0000);
    rd(tic_pkg::ADDR_CTRL, 8'h07);
    // counter off so no match can refill the flag behind the test
    wr(tic_pkg::ADDR_CTRL, 8'h05);
    rd(tic_pkg::ADDR_CTRL, 8'h05);
    wr(tic_pkg::ADDR_CTRL, 8'h01);
    wr(tic_pkg::ADDR_CTRL, 8'h05);
    rd(tic_pkg::ADDR_CTRL, 8'h01);
    int_en     <= 1'b1;
    power_down <= 1'b0;
    $display("test reload_and_wake done");
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({4'h0, busy, ack, irq, wake, rdata}, 16'h0000);
    rd(tic_pkg::ADDR_CTRL, 8'h00);
    rd(tic_pkg::ADDR_HOUR, 8'h00);
    $display("test mid_reset done");
    summarize();
  end
endmodule
`default_nettype wire
